// File: core/fifo_host_pkg.sv
// constants and carrier types for the parallel fifo host controller
// assumes a 25 MHz clock and the device's async fifo pins seen as synchronous inputs
package fifo_host_pkg;
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned RD_PULSE_NS = 50;
   localparam int unsigned RX_RECOVER_NS = 80;
   localparam int unsigned RD_GAP_NS = 50 + RX_RECOVER_NS;
   localparam int unsigned WR_PULSE_NS = 50;
   localparam int unsigned WR_GAP_NS = 50;
   localparam int unsigned WR_SETUP_NS = 20;
   localparam int unsigned CNT_W = 4;
   function automatic logic [CNT_W-1:0] cycles_min(input int unsigned ns);
      int unsigned c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      if (c < 1) c = 1;
      return CNT_W'(c);
   endfunction
   localparam logic [CNT_W-1:0] RD_PULSE_CYC = cycles_min(RD_PULSE_NS);
   localparam logic [CNT_W-1:0] RD_GAP_CYC = cycles_min(RD_GAP_NS);
   localparam logic [CNT_W-1:0] WR_PULSE_CYC = cycles_min(WR_PULSE_NS);
   localparam logic [CNT_W-1:0] WR_GAP_CYC = cycles_min(WR_GAP_NS);
   localparam logic [CNT_W-1:0] WR_SETUP_CYC = cycles_min(WR_SETUP_NS);
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_WR_SETUP = 3'b001,
      ST_WR_PULSE = 3'b010,
      ST_WR_GAP = 3'b011,
      ST_RD_PULSE = 3'b100,
      ST_RD_GAP = 3'b101
   } state_t;

   typedef struct packed {
      logic rd_n;
      logic wr;
      logic [7:0] data_out;
      logic data_oe;
   } pins_t;

   typedef struct packed {
      state_t st;
      logic [CNT_W-1:0] cnt;
      pins_t pins;
      logic tx_ready;
      logic [7:0] rx_data;
      logic rx_valid;
   } host_state_t;
endpackage

// File: core/fifo_host.sv
// host controller driving the parallel fifo port of a usb bridge device
// assumes device flags are synchronous to clk; one clock, flags used without synchroniser flops
`timescale 1ns/1ps
module fifo_host
   import fifo_host_pkg::*;
#(
   // clock period and strobe minimums in ns; each strobe is rounded up to whole clocks
   parameter int unsigned CLK_NS = CLK_PERIOD_NS,
   parameter int unsigned RD_LOW_NS = RD_PULSE_NS,
   parameter int unsigned RD_HIGH_NS = RD_GAP_NS,
   parameter int unsigned WR_LEAD_NS = WR_SETUP_NS,
   parameter int unsigned WR_HIGH_NS = WR_PULSE_NS,
   parameter int unsigned WR_LOW_NS = WR_GAP_NS
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready,
   output logic rx_valid,
   output logic [7:0] rx_data,
   input wire logic rx_ready,
   input wire logic tx_space_n,
   input wire logic rx_avail_n,
   output logic rd_n,
   output logic wr,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe
);
   host_state_t s_q, s_d;

   // rounding up keeps every strobe at or above its minimum for any clock period whose counts fit the cnt field
   // limitation: a count must fit the cnt field, so very fast clocks need a wider CNT_W
   function automatic logic [CNT_W-1:0] to_cycles(input int unsigned ns);
      int unsigned c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      if (c < 1) begin
         c = 1;
      end
      return CNT_W'(c);
   endfunction

   function automatic logic last_tick(input logic [CNT_W-1:0] c);
      return c == CNT_ONE;
   endfunction

   localparam logic [CNT_W-1:0] RD_LOW_CYC = to_cycles(RD_LOW_NS);
   localparam logic [CNT_W-1:0] RD_HIGH_CYC = to_cycles(RD_HIGH_NS);
   localparam logic [CNT_W-1:0] WR_LEAD_CYC = to_cycles(WR_LEAD_NS);
   localparam logic [CNT_W-1:0] WR_HIGH_CYC = to_cycles(WR_HIGH_NS);
   localparam logic [CNT_W-1:0] WR_LOW_CYC = to_cycles(WR_LOW_NS);

   always_comb begin
      s_d = s_q;
      if (s_q.cnt != CNT_ZERO) begin
         s_d.cnt = s_q.cnt - CNT_ONE;
      end
      if (s_q.rx_valid && rx_ready) begin
         s_d.rx_valid = 1'b0;
      end
      s_d.tx_ready = 1'b0;
      case (s_q.st)
         ST_IDLE: begin
            // reads first, once rx_valid is clear or being taken by rx_ready this cycle, so the device's receive side goes ahead of any waiting write
            if (!rx_avail_n && !s_d.rx_valid) begin
               s_d.pins.data_oe = 1'b0;
               s_d.pins.rd_n = 1'b0;
               s_d.cnt = RD_LOW_CYC;
               s_d.st = ST_RD_PULSE;
            end else if (tx_valid && !tx_space_n) begin
               s_d.pins.data_out = tx_data;
               s_d.pins.data_oe = 1'b1;
               s_d.tx_ready = 1'b1;
               s_d.cnt = WR_LEAD_CYC;
               s_d.st = ST_WR_SETUP;
            end
         end
         ST_WR_SETUP: begin
            if (last_tick(s_q.cnt)) begin
               s_d.pins.wr = 1'b1;
               s_d.cnt = WR_HIGH_CYC;
               s_d.st = ST_WR_PULSE;
            end
         end
         ST_WR_PULSE: begin
            if (last_tick(s_q.cnt)) begin
               s_d.pins.wr = 1'b0;
               s_d.cnt = WR_LOW_CYC;
               s_d.st = ST_WR_GAP;
            end
         end
         ST_WR_GAP: begin
            // flag may lag the strobe; the gap covers its rise before we look again
            if (last_tick(s_q.cnt)) begin
               s_d.st = ST_IDLE;
            end
         end
         ST_RD_PULSE: begin
            if (last_tick(s_q.cnt)) begin
               s_d.rx_data = data_in;
               s_d.rx_valid = 1'b1;
               s_d.pins.rd_n = 1'b1;
               s_d.cnt = RD_HIGH_CYC;
               s_d.st = ST_RD_GAP;
            end
         end
         ST_RD_GAP: begin
            if (last_tick(s_q.cnt)) begin
               s_d.st = ST_IDLE;
            end
         end
         default: begin
            s_d.st = ST_IDLE;
            s_d.pins.rd_n = 1'b1;
            s_d.pins.wr = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s_q.st <= ST_IDLE;
         s_q.cnt <= CNT_ZERO;
         s_q.pins.rd_n <= 1'b1;
         s_q.pins.wr <= 1'b0;
         s_q.pins.data_out <= BYTE_ZERO;
         s_q.pins.data_oe <= 1'b0;
         s_q.tx_ready <= 1'b0;
         s_q.rx_data <= BYTE_ZERO;
         s_q.rx_valid <= 1'b0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign tx_ready = s_q.tx_ready;
   assign rx_valid = s_q.rx_valid;
   assign rx_data = s_q.rx_data;
   assign rd_n = s_q.pins.rd_n;
   assign wr = s_q.pins.wr;
   assign data_out = s_q.pins.data_out;
   assign data_oe = s_q.pins.data_oe;
endmodule

// File: testbench/fifo_host_properties.sv
// pin timing checker for fifo_host
// assumes it is bound onto fifo_host
`timescale 1ns/1ps
module fifo_host_properties(
   input wire logic clk,
   input wire logic srst,
   input wire logic tx_space_n,
   input wire logic rx_avail_n,
   input wire logic rx_valid,
   input wire logic rd_n,
   input wire logic wr,
   input wire logic [7:0] data_out,
   input wire logic data_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   chk_wr_space: assert property ($rose(wr) |-> $past(!tx_space_n, 2))
      else $error("write without space");
   chk_rd_pulse: assert property ($fell(rd_n) |-> ##1 !rd_n ##1 rd_n)
      else $error("read pulse width");
   chk_rd_gap: assert property ($rose(rd_n) |-> rd_n[*4])
      else $error("read gap short");
   chk_wr_pulse: assert property ($rose(wr) |=> wr ##1 !wr)
      else $error("write pulse width");
   chk_wr_gap: assert property ($fell(wr) |-> !wr[*2])
      else $error("write gap short");
   chk_rd_drain: assert property ((!rx_avail_n && !rx_valid && rd_n)[*8] |=> !rd_n)
      else $error("waiting byte not read");
   chk_bus_release: assert property (!rd_n |-> !data_oe)
      else $error("bus driven during read");
   chk_wr_data: assert property (wr |-> data_oe && $stable(data_out))
      else $error("write data moved under strobe");
   cover property ($rose(wr));
   cover property ($fell(rd_n));
   cover property (!rd_n ##[1:8] wr);
endmodule
bind fifo_host fifo_host_properties u_props(.clk, .srst, .tx_space_n, .rx_avail_n,
   .rx_valid, .rd_n, .wr, .data_out, .data_oe);

// File: testbench/fifo_dev_model.sv
// behavioural model of the usb fifo device pins
// assumes the bench loads rxq and empties txq directly
`timescale 1ns/1ps
module fifo_dev_model(
   input wire logic rd_n,
   input wire logic wr,
   input wire logic [7:0] data_out,
   input wire logic data_oe,
   output logic tx_space_n,
   output logic rx_avail_n,
   output logic [7:0] bus
);
   logic [7:0] rxq[$], txq[$], last = 8'h00;
   logic rx_hold = 0, tx_hold = 0, rd_ok = 0;
   // flags follow the buffers and the hold after each strobe, never a rate setting
   assign rx_avail_n = rx_hold || rxq.size() == 0;
   assign tx_space_n = tx_hold || txq.size() >= 128;
   // released bus shows the inverse so a stale value cannot pass
   assign bus = !rd_n && rd_ok ? rxq[0] : data_oe ? data_out : ~last;
   // read data is valid only after the access time, so an early sample gets junk
   always @(rd_n) begin
      rd_ok = 0;
      if (!rd_n) #50 rd_ok = !rd_n;
   end
   always @(negedge rd_n) begin
      @(posedge rd_n) last = rxq.pop_front();
      rx_hold = 1;
      #85 rx_hold = 0;
   end
   always @(posedge wr) begin
      tx_hold = 1;
      @(negedge wr) txq.push_back(bus);
      #85 tx_hold = 0;
   end
endmodule

// File: testbench/tb.sv
// self-checking bench for fifo_host against the device model
// assumes fifo_dev_model stands on the pin side
`timescale 1ns/1ps
module tb;
   logic clk = 0, srst = 1, ce = 1, tx_valid = 0, rx_ready = 0, tx_ready, rx_valid;
   logic rd_n, wr, data_oe, tx_space_n, rx_avail_n;
   logic [7:0] tx_data = 8'h00, rx_data, data_in, data_out;
   logic [7:0] exp_rx[$], exp_tx[$];
   int bad_count = 0, cmp_count = 0;
   initial forever #20 clk = ~clk;
   fifo_host u_fifo_host(.clk, .srst, .ce, .tx_valid, .tx_data, .tx_ready,
      .rx_valid, .rx_data, .rx_ready, .tx_space_n, .rx_avail_n, .rd_n, .wr,
      .data_in, .data_out, .data_oe);
   fifo_dev_model dev(.rd_n, .wr, .data_out, .data_oe, .tx_space_n, .rx_avail_n,
      .bus(data_in));
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %h not %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic feed(input int n);
      logic [7:0] b;
      repeat (n) begin
         b = $urandom;
         dev.rxq.push_back(b);
         exp_rx.push_back(b);
      end
   endtask
   task automatic send(input int n);
      @(posedge clk) #1;
      tx_valid = 1;
      repeat (n) begin
         tx_data = $urandom;
         @(negedge clk);
         while (!tx_ready) @(negedge clk);
         @(posedge clk) #1;
      end
      tx_valid = 0;
   endtask
   task automatic drain;
      check(8'(dev.txq.size()), 8'(exp_tx.size()));
      while (dev.txq.size() > 0) check(dev.txq.pop_front(), exp_tx.pop_front());
   endtask
   always @(posedge clk) #1 rx_ready = $urandom % 4 != 0;
   always @(negedge clk) begin
      if (rx_valid && rx_ready) check(rx_data, exp_rx.pop_front());
      if (tx_ready) exp_tx.push_back(tx_data);
   end
   initial begin
      void'($urandom(37946));
      repeat (20) @(posedge clk);
      #1 srst = 0;
      feed(30);
      wait (exp_rx.size() == 0);
      $display("test 1 done");
      send(128);
      @(posedge clk) #1 tx_valid = 1;
      repeat (20) @(posedge clk);
      #1 check(8'(exp_tx.size()), 8'h80);
      ce = 0;
      drain;
      repeat (8) @(posedge clk);
      #1 check(8'(exp_tx.size()), 8'h00);
      tx_valid = 0;
      ce = 1;
      $display("test 2 done");
      feed(40);
      send(20);
      wait (exp_rx.size() == 0);
      repeat (4) @(posedge clk);
      check(8'(exp_tx.size()), 8'h14);
      drain;
      $display("test 3 done");
      report_and_stop;
   end
   initial begin
      #400000;
      bad_count++;
      report_and_stop;
   end
endmodule
